// File: slg_pkg.sv
// package of constants for the stack limit and ram guard block
package slg_pkg;
    // register offsets on the plain register port
    localparam logic [15:0] ADDR_BOOT_RAM_CTRL   = 16'h0750; // boot ram segment control
    localparam logic [15:0] ADDR_SECURE_RAM_CTRL = 16'h0752; // secure ram segment control
    localparam logic [15:0] ADDR_STACK_LIMIT     = 16'h0020; // stack limit register
    localparam logic [15:0] ADDR_STACK_POINTER   = 16'h001e; // stack pointer register
    localparam logic [15:0] ADDR_GUARD_STATUS    = 16'h0754; // sticky violation status
    // reset values
    localparam logic [15:0] RST_SEG_CTRL         = 16'h0000; // both segment controls
    localparam logic [15:0] RST_STACK_POINTER    = 16'h0800; // pointer starts at the floor
    // fixed floor protecting the special function space
    localparam logic [15:0] STACK_FLOOR          = 16'h0800;
    // segment control field positions
    localparam int          SEG_EN_BIT           = 0;        // segment protection enable
    localparam int          SEG_RD_BIT           = 1;        // read guard
    localparam int          SEG_WR_BIT           = 2;        // write guard
    localparam logic [15:0] SEG_CTRL_MASK        = 16'h0007; // implemented bits
    // stack operation codes from the address generator
    typedef enum logic [1:0] {
        SLG_OP_NONE,
        SLG_OP_PUSH,
        SLG_OP_POP,
        SLG_OP_ACCESS
    } slg_op_t;
    // kind of program counter push
    typedef enum logic [1:0] {
        SLG_PC_DATA,
        SLG_PC_CALL,
        SLG_PC_EXCEPT
    } slg_pc_t;
endpackage

// File: slg_seg_guard.sv
// protected ram segment access check
`timescale 1ns/1ps
module slg_seg_guard (
    // segment window and control
    input  wire logic [15:0] i_seg_base,
    input  wire logic [15:0] i_seg_top,
    input  wire logic [15:0] i_ctrl,
    // access under test
    input  wire logic [15:0] i_addr,
    input  wire logic        i_rd,
    input  wire logic        i_wr,
    input  wire logic        i_code_ok,
    // result
    output logic             o_deny
);
    logic hit; // access falls in the protected window
    always_comb begin
        hit    = (i_addr >= i_seg_base) && (i_addr <= i_seg_top);
        // only the owning code segment may touch an enabled segment
        o_deny = i_ctrl[slg_pkg::SEG_EN_BIT] && hit && (i_rd || i_wr) && !i_code_ok;
    end
endmodule // slg_seg_guard

// File: slg_stack_guard.sv
// stack limit checker, return word former and ram segment guard
// Notes on behaviour
// - pointer holds next free word, grows upward
// - push writes then increments; pop predecrements
// - call push clears top pc bit
// - exception push puts status byte with pc
// - stack limit has no reset value
// - stack limit bit zero reads zero
// - every stack address compared against limit
// - push at limit allowed, next push traps
// - pointer below floor raises underflow trap
// - boot ram only from boot code
// - secure ram only from secure code
// - segment registers absent in smallest variant
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module slg_stack_guard #(
    parameter bit HAS_SEG_REGS = 1'b1 // zero for the smallest ram and flash variant
) (
    // clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rst,
    // register port
    input  wire logic [15:0]          i_reg_addr,
    input  wire logic [15:0]          i_reg_wdata,
    input  wire logic                 i_reg_wr,
    input  wire logic                 i_reg_rd,
    output logic      [15:0]          o_reg_rdata,
    // stack operation from the address generator
    input  wire slg_pkg::slg_op_t     i_stk_op,
    input  wire slg_pkg::slg_pc_t     i_pc_kind,
    input  wire logic [22:0]          i_pc,
    input  wire logic [7:0]           i_status_low_byte,
    input  wire logic [15:0]          i_push_data,
    // stack memory request
    output logic      [15:0]          o_stk_addr,
    output logic      [15:0]          o_stk_wdata,
    output logic                      o_stk_wr,
    output logic                      o_stk_rd,
    // trap request to the exception controller
    output logic                      o_stack_trap,
    // data ram access for segment guarding
    input  wire logic [15:0]          i_ram_addr,
    input  wire logic                 i_ram_rd,
    input  wire logic                 i_ram_wr,
    input  wire logic                 i_exec_boot,
    input  wire logic                 i_exec_secure,
    input  wire logic [15:0]          i_boot_seg_base,
    input  wire logic [15:0]          i_boot_seg_top,
    input  wire logic [15:0]          i_sec_seg_base,
    input  wire logic [15:0]          i_sec_seg_top,
    output logic                      o_ram_deny
);
    // register state
    logic [15:0] stack_pointer_reg, stack_pointer_next; // next free word
    logic [15:0] stack_limit_reg, stack_limit_next;     // upper stack boundary
    logic [15:0] boot_ram_ctrl_reg, boot_ram_ctrl_next;
    logic [15:0] sec_ram_ctrl_reg, sec_ram_ctrl_next;
    logic [15:0] status_reg, status_next;               // sticky violation flags
    logic [15:0] rdata_reg, rdata_next;
    // stack request outputs
    logic [15:0] stk_addr_reg, stk_addr_next;
    logic [15:0] stk_wdata_reg, stk_wdata_next;
    logic        stk_wr_reg, stk_wr_next;
    logic        stk_rd_reg, stk_rd_next;
    logic        trap_reg, trap_next;
    logic        deny_reg, deny_next;
    // combinational helpers
    logic [15:0] ea;          // effective stack address
    logic        over_limit;  // address beyond the limit
    logic        under_floor; // address below the floor
    logic        boot_deny, sec_deny;

    // word aligned limit value
    function automatic logic [15:0] align_word(input logic [15:0] v);
        align_word = {v[15:1], 1'b0};
    endfunction

    // segment guards, one per protected segment
    slg_seg_guard u_boot_guard (
        .i_seg_base (i_boot_seg_base),
        .i_seg_top  (i_boot_seg_top),
        .i_ctrl     (boot_ram_ctrl_reg),
        .i_addr     (i_ram_addr),
        .i_rd       (i_ram_rd),
        .i_wr       (i_ram_wr),
        .i_code_ok  (i_exec_boot),
        .o_deny     (boot_deny)
    );
    slg_seg_guard u_sec_guard (
        .i_seg_base (i_sec_seg_base),
        .i_seg_top  (i_sec_seg_top),
        .i_ctrl     (sec_ram_ctrl_reg),
        .i_addr     (i_ram_addr),
        .i_rd       (i_ram_rd),
        .i_wr       (i_ram_wr),
        .i_code_ok  (i_exec_secure),
        .o_deny     (sec_deny)
    );

    // stack address, checks and next state of all registers
    always_comb begin
        stack_pointer_next = stack_pointer_reg;
        stack_limit_next   = stack_limit_reg;
        boot_ram_ctrl_next = boot_ram_ctrl_reg;
        sec_ram_ctrl_next  = sec_ram_ctrl_reg;
        status_next        = status_reg;
        rdata_next         = 16'h0000;
        stk_addr_next      = stk_addr_reg;
        stk_wdata_next     = stk_wdata_reg;
        stk_wr_next        = 1'b0;
        stk_rd_next        = 1'b0;
        trap_next          = 1'b0;
        // pop uses the predecremented pointer, others the pointer itself
        ea = (i_stk_op == slg_pkg::SLG_OP_POP) ? stack_pointer_reg - 16'h0002
                                               : stack_pointer_reg;
        // equality with the limit is legal; only beyond it traps
        over_limit  = ea > stack_limit_reg;
        under_floor = ea < slg_pkg::STACK_FLOOR;
        // software writes first so a same-cycle push or pop overrides a pointer write
        if (i_reg_wr) begin
            case (i_reg_addr)
                slg_pkg::ADDR_STACK_POINTER: stack_pointer_next = align_word(i_reg_wdata);
                slg_pkg::ADDR_STACK_LIMIT:   stack_limit_next = align_word(i_reg_wdata);
                slg_pkg::ADDR_BOOT_RAM_CTRL:
                    if (HAS_SEG_REGS) boot_ram_ctrl_next = i_reg_wdata & slg_pkg::SEG_CTRL_MASK;
                slg_pkg::ADDR_SECURE_RAM_CTRL:
                    if (HAS_SEG_REGS) sec_ram_ctrl_next = i_reg_wdata & slg_pkg::SEG_CTRL_MASK;
                slg_pkg::ADDR_GUARD_STATUS:  status_next = status_reg & ~i_reg_wdata;
                default: ;
            endcase
        end
        if (i_reg_rd) begin
            case (i_reg_addr)
                slg_pkg::ADDR_STACK_POINTER:   rdata_next = stack_pointer_reg;
                slg_pkg::ADDR_STACK_LIMIT:     rdata_next = align_word(stack_limit_reg);
                slg_pkg::ADDR_BOOT_RAM_CTRL:   rdata_next = boot_ram_ctrl_reg;
                slg_pkg::ADDR_SECURE_RAM_CTRL: rdata_next = sec_ram_ctrl_reg;
                slg_pkg::ADDR_GUARD_STATUS:    rdata_next = status_reg;
                default:                       rdata_next = 16'h0000;
            endcase
        end
        // stack operations
        case (i_stk_op)
            slg_pkg::SLG_OP_PUSH: begin
                stk_addr_next      = ea;
                stk_wr_next        = 1'b1;
                stack_pointer_next = stack_pointer_reg + 16'h0002;
                case (i_pc_kind)
                    slg_pkg::SLG_PC_CALL:
                        stk_wdata_next = {9'h000, i_pc[22:16]};
                    slg_pkg::SLG_PC_EXCEPT:
                        stk_wdata_next = {i_status_low_byte, 1'b0, i_pc[22:16]};
                    default:
                        stk_wdata_next = i_push_data;
                endcase
            end
            slg_pkg::SLG_OP_POP: begin
                stk_addr_next      = ea;
                stk_rd_next        = 1'b1;
                stack_pointer_next = ea;
            end
            slg_pkg::SLG_OP_ACCESS: begin
                stk_addr_next = ea;
                stk_rd_next   = 1'b1;
            end
            default: ;
        endcase
        // one trap pulse per offending access
        if (i_stk_op != slg_pkg::SLG_OP_NONE) begin
            trap_next = over_limit || under_floor;
            // hardware set wins over a software clear in the same cycle
            if (over_limit)  status_next[0] = 1'b1;
            if (under_floor) status_next[1] = 1'b1;
        end
        deny_next = boot_deny || sec_deny;
        if (boot_deny) status_next[2] = 1'b1;
        if (sec_deny)  status_next[3] = 1'b1;
        if (!HAS_SEG_REGS) begin
            boot_ram_ctrl_next = slg_pkg::RST_SEG_CTRL;
            sec_ram_ctrl_next  = slg_pkg::RST_SEG_CTRL;
        end
    end

    // registers with reset; the limit is left out on purpose
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            stack_pointer_reg <= slg_pkg::RST_STACK_POINTER;
            boot_ram_ctrl_reg <= slg_pkg::RST_SEG_CTRL;
            sec_ram_ctrl_reg  <= slg_pkg::RST_SEG_CTRL;
            status_reg        <= 16'h0000;
            rdata_reg         <= 16'h0000;
            stk_addr_reg      <= 16'h0000;
            stk_wdata_reg     <= 16'h0000;
            stk_wr_reg        <= 1'b0;
            stk_rd_reg        <= 1'b0;
            trap_reg          <= 1'b0;
            deny_reg          <= 1'b0;
        end else begin
            stack_pointer_reg <= stack_pointer_next;
            boot_ram_ctrl_reg <= boot_ram_ctrl_next;
            sec_ram_ctrl_reg  <= sec_ram_ctrl_next;
            status_reg        <= status_next;
            rdata_reg         <= rdata_next;
            stk_addr_reg      <= stk_addr_next;
            stk_wdata_reg     <= stk_wdata_next;
            stk_wr_reg        <= stk_wr_next;
            stk_rd_reg        <= stk_rd_next;
            trap_reg          <= trap_next;
            deny_reg          <= deny_next;
        end
    end

    // limit has no reset; software must load it before use
    always_ff @(posedge i_clk) begin
        stack_limit_reg <= stack_limit_next;
    end

    assign o_reg_rdata  = rdata_reg;
    assign o_stk_addr   = stk_addr_reg;
    assign o_stk_wdata  = stk_wdata_reg;
    assign o_stk_wr     = stk_wr_reg;
    assign o_stk_rd     = stk_rd_reg;
    assign o_stack_trap = trap_reg;
    assign o_ram_deny   = deny_reg;

    // checks on the pointer and the driven outputs
    a_push_increments: assert property (@(posedge i_clk) disable iff (i_rst)
        i_stk_op == slg_pkg::SLG_OP_PUSH |=> stack_pointer_reg == $past(stack_pointer_reg) + 16'h0002)
        else $error("push did not advance pointer");
    a_pop_predec: assert property (@(posedge i_clk) disable iff (i_rst)
        i_stk_op == slg_pkg::SLG_OP_POP |=> o_stk_addr == $past(stack_pointer_reg) - 16'h0002)
        else $error("pop address not predecremented");
    a_push_at_ptr: assert property (@(posedge i_clk) disable iff (i_rst)
        i_stk_op == slg_pkg::SLG_OP_PUSH |=> o_stk_wr && o_stk_addr == $past(stack_pointer_reg))
        else $error("push not at pointer");
    a_call_msb_clear: assert property (@(posedge i_clk) disable iff (i_rst)
        i_stk_op == slg_pkg::SLG_OP_PUSH && i_pc_kind == slg_pkg::SLG_PC_CALL
        |=> o_stk_wdata[15:7] == 9'h000)
        else $error("call push top bits set");
    a_except_status: assert property (@(posedge i_clk) disable iff (i_rst)
        i_stk_op == slg_pkg::SLG_OP_PUSH && i_pc_kind == slg_pkg::SLG_PC_EXCEPT
        |=> o_stk_wdata[15:8] == $past(i_status_low_byte))
        else $error("exception push lacks status byte");
    a_limit_aligned: assert property (@(posedge i_clk) disable iff (i_rst)
        i_reg_rd && i_reg_addr == slg_pkg::ADDR_STACK_LIMIT |=> o_reg_rdata[0] == 1'b0)
        else $error("limit bit zero not clear");
    a_equal_no_trap: assert property (@(posedge i_clk) disable iff (i_rst)
        i_stk_op == slg_pkg::SLG_OP_PUSH && stack_pointer_reg == stack_limit_reg
        && stack_pointer_reg >= slg_pkg::STACK_FLOOR |=> !o_stack_trap)
        else $error("push at limit trapped");
    a_over_trap: assert property (@(posedge i_clk) disable iff (i_rst)
        i_stk_op == slg_pkg::SLG_OP_PUSH && stack_pointer_reg > stack_limit_reg |=> o_stack_trap)
        else $error("push beyond limit missed");
    a_floor_trap: assert property (@(posedge i_clk) disable iff (i_rst)
        i_stk_op == slg_pkg::SLG_OP_ACCESS && stack_pointer_reg < slg_pkg::STACK_FLOOR
        |=> o_stack_trap)
        else $error("underflow trap missed");
    a_trap_single: assert property (@(posedge i_clk) disable iff (i_rst)
        o_stack_trap |-> $past(i_stk_op) != slg_pkg::SLG_OP_NONE)
        else $error("trap without access");
    a_boot_deny: assert property (@(posedge i_clk) disable iff (i_rst)
        boot_ram_ctrl_reg[slg_pkg::SEG_EN_BIT] && i_ram_rd && !i_exec_boot
        && i_ram_addr >= i_boot_seg_base && i_ram_addr <= i_boot_seg_top |=> o_ram_deny)
        else $error("boot segment not guarded");
    a_secure_deny: assert property (@(posedge i_clk) disable iff (i_rst)
        sec_ram_ctrl_reg[slg_pkg::SEG_EN_BIT] && i_ram_wr && !i_exec_secure
        && i_ram_addr >= i_sec_seg_base && i_ram_addr <= i_sec_seg_top |=> o_ram_deny)
        else $error("secure segment not guarded");
endmodule // slg_stack_guard

// File: slg_agu_model.sv
// address generator and exception controller model facing the stack guard
`timescale 1ns/1ps
module slg_agu_model (
    // clock and bench command
    input  wire logic             i_clk,
    input  wire logic             i_go,
    input  wire slg_pkg::slg_op_t i_op,
    input  wire slg_pkg::slg_pc_t i_kind,
    input  wire logic [22:0]      i_pc,
    input  wire logic [7:0]       i_status,
    input  wire logic [15:0]      i_data,
    // stack request towards the guard
    output slg_pkg::slg_op_t      o_stk_op,
    output slg_pkg::slg_pc_t      o_pc_kind,
    output logic [22:0]           o_pc,
    output logic [7:0]            o_status_low_byte,
    output logic [15:0]           o_push_data,
    // exception controller side
    input  wire logic             i_trap,
    output int                    o_trap_cnt
);
    // quiet start so the guard sees no request before reset ends
    initial begin
        o_stk_op = slg_pkg::SLG_OP_NONE;
        o_pc_kind = slg_pkg::SLG_PC_DATA;
        o_pc = '0;
        o_status_low_byte = '0;
        o_push_data = '0;
        o_trap_cnt = 0;
    end
    // one request per command; idle payload turns over so stale data never matches
    always @(posedge i_clk) begin
        if (i_go) begin
            o_stk_op <= i_op;
            o_pc_kind <= i_kind;
            o_pc <= i_pc;
            o_status_low_byte <= i_status;
            o_push_data <= i_data;
        end else begin
            o_stk_op <= slg_pkg::SLG_OP_NONE;
            o_pc <= ~o_pc;
            o_status_low_byte <= ~o_status_low_byte;
            o_push_data <= ~o_push_data;
        end
        // each cycle of trap request counts as one taken trap
        if (i_trap) begin
            o_trap_cnt <= o_trap_cnt + 1;
        end
    end
endmodule // slg_agu_model

// File: stack_limit_and_ram_guard_bench.sv
// self-checking bench for the stack limit and ram guard
`timescale 1ns/1ps
module stack_limit_and_ram_guard_bench;
    typedef struct {logic [15:0] a; logic [15:0] d; logic wr; logic rd; logic tr;} slg_exp_t;
    logic clk, rst, started, go, reg_wr, reg_rd, ram_rd, ram_wr, ex_boot, ex_sec;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, ram_addr, data, ddata, stk_addr, stk_wdata;
    logic [22:0] pc, dpc;
    logic [7:0] status, dstat;
    logic stk_wr, stk_rd, trap, deny, due_s, due_r, due_m;
    slg_pkg::slg_op_t op, stk_op;
    slg_pkg::slg_pc_t kind, pc_kind;
    logic [15:0] sp, lim, q_reg[$];  // bench copy of pointer and limit
    logic q_ram[$];
    slg_exp_t q_stk[$], m_e;
    int miscompares, n_tests, exp_traps, trap_cnt;
    slg_stack_guard #(.HAS_SEG_REGS(1'b1)) dut_u (.i_clk(clk), .i_rst(rst),
        .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
        .o_reg_rdata(reg_rdata), .i_stk_op(stk_op), .i_pc_kind(pc_kind), .i_pc(dpc),
        .i_status_low_byte(dstat), .i_push_data(ddata), .o_stk_addr(stk_addr),
        .o_stk_wdata(stk_wdata), .o_stk_wr(stk_wr), .o_stk_rd(stk_rd), .o_stack_trap(trap),
        .i_ram_addr(ram_addr), .i_ram_rd(ram_rd), .i_ram_wr(ram_wr), .i_exec_boot(ex_boot),
        .i_exec_secure(ex_sec), .i_boot_seg_base(16'h1000), .i_boot_seg_top(16'h10fe),
        .i_sec_seg_base(16'h2000), .i_sec_seg_top(16'h20fe), .o_ram_deny(deny));
    slg_agu_model agu_u (.i_clk(clk), .i_go(go), .i_op(op), .i_kind(kind), .i_pc(pc),
        .i_status(status), .i_data(data), .o_stk_op(stk_op), .o_pc_kind(pc_kind), .o_pc(dpc),
        .o_status_low_byte(dstat), .o_push_data(ddata), .i_trap(trap), .o_trap_cnt(trap_cnt));
    // 250 MHz core clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // counted comparison with an immediate report
    task automatic chk(input bit ok, input string m);
        n_tests++;
        if (!ok) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // every task sets all strobes so none lingers into the next cycle
    task automatic strobes(input logic w, r, g, mr, mw);
        reg_wr <= w;
        reg_rd <= r;
        go <= g;
        ram_rd <= mr;
        ram_wr <= mw;
    endtask
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            strobes(0, 0, 0, 0, 0);
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        strobes(1, 0, 0, 0, 0);
    endtask
    task automatic rd_reg(input logic [15:0] a, x);
        @(posedge clk);
        q_reg.push_back(x);
        reg_addr <= a;
        strobes(0, 1, 0, 0, 0);
    endtask
    // pointer writes keep the bench copy in step
    task automatic set_sp(input logic [15:0] v);
        wr_reg(slg_pkg::ADDR_STACK_POINTER, v);
        sp = v;
    endtask
    // push uses the pointer, pop the pointer less one word; both meet limit and floor
    task automatic stk(input slg_pkg::slg_op_t o, input slg_pkg::slg_pc_t k);
        slg_exp_t e;
        logic [22:0] r_pc;
        logic [7:0] r_st;
        logic [15:0] r_d;
        @(posedge clk);
        r_pc = 23'($urandom);
        r_st = 8'($urandom);
        r_d = 16'($urandom);
        e.wr = (o == slg_pkg::SLG_OP_PUSH);
        e.rd = !e.wr;
        e.a = (o == slg_pkg::SLG_OP_POP) ? sp - 16'h0002 : sp;
        e.tr = (e.a > lim) || (e.a < slg_pkg::STACK_FLOOR);
        e.d = (k == slg_pkg::SLG_PC_CALL) ? {9'h000, r_pc[22:16]} :
              (k == slg_pkg::SLG_PC_EXCEPT) ? {r_st, 1'b0, r_pc[22:16]} : r_d;
        // the pointer moves even on a trapping push or pop; a plain access leaves it
        if (o != slg_pkg::SLG_OP_ACCESS) sp = e.wr ? sp + 16'h0002 : e.a;
        exp_traps += e.tr;
        q_stk.push_back(e);
        op <= o;
        kind <= k;
        pc <= r_pc;
        status <= r_st;
        data <= r_d;
        strobes(0, 0, 1, 0, 0);
    endtask
    task automatic ram(input logic [15:0] a, input logic b, s, w, x);
        @(posedge clk);
        q_ram.push_back(x);
        ram_addr <= a;
        ex_boot <= b;
        ex_sec <= s;
        strobes(0, 0, 0, !w, w);
    endtask
    // results stand one cycle after the request; oldest note is compared
    always @(posedge clk) begin
        if (due_s) begin
            m_e = q_stk.pop_front();
            chk(stk_addr === m_e.a && trap === m_e.tr, "stack address or trap");
            chk(stk_wr === m_e.wr && stk_rd === m_e.rd, "stack strobe");
            if (m_e.wr) chk(stk_wdata === m_e.d, "pushed word");
        end else if (started) begin
            chk(trap === 1'b0 && stk_wr === 1'b0 && stk_rd === 1'b0, "stray pulse");
        end
        if (due_r) chk(reg_rdata === q_reg.pop_front(), "read data");
        if (due_m) chk(deny === q_ram.pop_front(), "segment deny");
        due_s <= (stk_op != slg_pkg::SLG_OP_NONE);
        due_r <= reg_rd;
        due_m <= ram_rd | ram_wr;
    end
    // hang guard, far beyond the hundred or so cycles the sequence needs
    initial begin
        repeat (4000) @(posedge clk);
        miscompares++;
        print_verdict();
    end
    initial begin
        {rst, started, go, reg_wr, reg_rd, ram_rd, ram_wr, ex_boot, ex_sec} = 9'h100;
        {reg_addr, reg_wdata, ram_addr, data, pc, status} = '0;
        {due_s, due_r, due_m} = '0;
        op = slg_pkg::SLG_OP_NONE;
        kind = slg_pkg::SLG_PC_DATA;
        {miscompares, n_tests, exp_traps} = '0;
        void'($urandom(27));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        started <= 1'b1;
        rd_reg(slg_pkg::ADDR_BOOT_RAM_CTRL, slg_pkg::RST_SEG_CTRL);
        rd_reg(slg_pkg::ADDR_SECURE_RAM_CTRL, slg_pkg::RST_SEG_CTRL);
        rd_reg(slg_pkg::ADDR_STACK_POINTER, slg_pkg::RST_STACK_POINTER);
        rd_reg(16'h0100, 16'h0000);
        // limit is never read before it is written, since reset leaves it open
        wr_reg(slg_pkg::ADDR_STACK_LIMIT, 16'h0805);
        lim = 16'h0804;
        rd_reg(slg_pkg::ADDR_STACK_LIMIT, lim);
        sp = slg_pkg::RST_STACK_POINTER;
        idle(1);
        stk(slg_pkg::SLG_OP_PUSH, slg_pkg::SLG_PC_DATA);
        stk(slg_pkg::SLG_OP_PUSH, slg_pkg::SLG_PC_CALL);
        stk(slg_pkg::SLG_OP_PUSH, slg_pkg::SLG_PC_EXCEPT);
        idle(2);
        rd_reg(slg_pkg::ADDR_STACK_POINTER, 16'h0806);
        stk(slg_pkg::SLG_OP_PUSH, slg_pkg::SLG_PC_DATA);
        idle(2);
        set_sp(16'h0806);
        repeat (3) stk(slg_pkg::SLG_OP_POP, slg_pkg::SLG_PC_DATA);
        idle(2);
        rd_reg(slg_pkg::ADDR_STACK_POINTER, 16'h0800);
        stk(slg_pkg::SLG_OP_POP, slg_pkg::SLG_PC_DATA);
        idle(2);
        set_sp(16'h07fc);
        stk(slg_pkg::SLG_OP_PUSH, slg_pkg::SLG_PC_DATA);
        stk(slg_pkg::SLG_OP_ACCESS, slg_pkg::SLG_PC_DATA);
        idle(2);
        // random push kinds back to back, then unwind
        wr_reg(slg_pkg::ADDR_STACK_LIMIT, 16'h0ffe);
        lim = 16'h0ffe;
        set_sp(16'h0800);
        idle(1);
        repeat (8) stk(slg_pkg::SLG_OP_PUSH, slg_pkg::slg_pc_t'($urandom_range(2)));
        stk(slg_pkg::SLG_OP_ACCESS, slg_pkg::SLG_PC_DATA);
        repeat (8) stk(slg_pkg::SLG_OP_POP, slg_pkg::SLG_PC_DATA);
        idle(2);
        wr_reg(slg_pkg::ADDR_BOOT_RAM_CTRL, 16'hffff);
        rd_reg(slg_pkg::ADDR_BOOT_RAM_CTRL, slg_pkg::SEG_CTRL_MASK);
        wr_reg(slg_pkg::ADDR_SECURE_RAM_CTRL, 16'h0001);
        // bit0 picks the segment, bit1 inside or outside, bits 2 and 3 the running code
        for (int i = 0; i < 16; i++) begin
            ram((i[0] ? 16'h2000 : 16'h1000) + (i[1] ? 16'h0010 : 16'h0200), i[2], i[3],
                1'($urandom), i[1] && (i[0] ? !i[3] : !i[2]));
        end
        wr_reg(slg_pkg::ADDR_BOOT_RAM_CTRL, 16'h0000);
        ram(16'h1010, 1'b0, 1'b0, 1'b0, 1'b0);
        // every kind of violation has been seen at least once, so all four sticky flags stand
        rd_reg(slg_pkg::ADDR_GUARD_STATUS, 16'h000f);
        wr_reg(slg_pkg::ADDR_GUARD_STATUS, 16'hffff);
        rd_reg(slg_pkg::ADDR_GUARD_STATUS, 16'h0000);
        idle(3);
        chk(trap_cnt == exp_traps, "trap count");
        print_verdict();
    end
endmodule // stack_limit_and_ram_guard_bench
